// [rtl/plcc_pkg.sv]
package plcc_pkg;

  // ----------------------------------------------------------------
  // Clock and bus
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 4;
  localparam int unsigned AXI_DATA_W    = 32;
  localparam int unsigned AXI_ADDR_W    = 12;
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;

  // ----------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [7:0] IDX_LOOP1_CAL_WAITS  = 8'h77;
  localparam logic [7:0] IDX_LOOP1_BW_SELECT  = 8'h78;
  localparam logic [7:0] IDX_CAL_CONTROL      = 8'h7A;
  localparam logic [7:0] IDX_LOOP2_PULSE      = 8'h83;
  localparam logic [7:0] IDX_LOOP2_FILTER     = 8'h84;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int unsigned SETTLE_SEL_LSB    = 2;
  localparam int unsigned OSC_SEL_LSB       = 0;
  localparam int unsigned NARROW_BW_BIT     = 0;
  localparam int unsigned PULSE_WIDEN_BIT   = 7;
  localparam int unsigned FILTER_SEL_LSB    = 0;
  localparam int unsigned CAL_START_BIT     = 0;
  localparam int unsigned STAT_BUSY_BIT     = 0;
  localparam int unsigned STAT_DONE_BIT     = 1;
  localparam int unsigned STAT_OSC_BIT      = 2;
  localparam int unsigned STAT_LOOP_BIT     = 3;
  localparam logic [1:0]  SETTLE_SEL_RST    = 2'h0;
  localparam logic [1:0]  OSC_SEL_RST       = 2'h1;
  localparam logic        NARROW_BW_RST     = 1'b0;
  localparam logic        PULSE_WIDEN_RST   = 1'b0;
  localparam logic [2:0]  FILTER_SEL_RST    = 3'h3;
  localparam logic [2:0]  FILTER_SECOND_ORD = 3'h3;
  localparam logic [2:0]  FILTER_THIRD_ORD  = 3'h7;

  // ----------------------------------------------------------------
  // Analog figures steered by the fields
  // ----------------------------------------------------------------
  localparam int unsigned NARROW_BW_HZ      = 200;
  localparam int unsigned PULSE_NORMAL_PS   = 200;
  localparam int unsigned PULSE_WIDE_PS     = 600;

  // ----------------------------------------------------------------
  // Wait periods as printed, and cycle counts rounded up
  // ----------------------------------------------------------------
  localparam int unsigned SETTLE0_US = 30;
  localparam int unsigned SETTLE1_US = 300;
  localparam int unsigned SETTLE2_MS = 30;
  localparam int unsigned SETTLE3_MS = 300;
  localparam int unsigned OSC0_US    = 20;
  localparam int unsigned OSC1_US    = 400;
  localparam int unsigned OSC2_MS    = 8;
  localparam int unsigned OSC3_MS    = 200;

  localparam int unsigned SETTLE0_CYC = (SETTLE0_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned SETTLE1_CYC = (SETTLE1_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned SETTLE2_CYC =
    (SETTLE2_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned SETTLE3_CYC =
    (SETTLE3_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned OSC0_CYC = (OSC0_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned OSC1_CYC = (OSC1_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned OSC2_CYC = (OSC2_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned OSC3_CYC = (OSC3_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam int unsigned WAIT_CNT_W = 27;

  // ----------------------------------------------------------------
  // Calibration sequence states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    CAL_IDLE      = 3'b001,
    CAL_OSC_WAIT  = 3'b010,
    CAL_LOOP_WAIT = 3'b100
  } plcc_cal_state_t;

endpackage

// [rtl/plcc_wait_timer.sv]
`timescale 1ns/1ps
`default_nettype none

module plcc_wait_timer #(
  parameter int unsigned CNT_W = 27
) (
  input  wire logic             ref_clk,
  input  wire logic             reset_n,
  input  wire logic             start,
  input  wire logic [CNT_W-1:0] length,
  output logic                  busy,
  output logic                  done
);

  // ----------------------------------------------------------------
  // Down counter: done pulses exactly length cycles after start
  // ----------------------------------------------------------------
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  logic             done_q;
  logic             last_w;

  assign last_w = (cnt_q == CNT_W'(1));
  assign cnt_d  = start ? length : (cnt_q != '0) ? cnt_q - CNT_W'(1) : cnt_q;
  assign busy   = (cnt_q != '0);
  assign done   = done_q;

  // Zero length would never finish, so it is refused above
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      cnt_q  <= '0;
      done_q <= 1'b0;
    end else begin
      cnt_q  <= cnt_d;
      done_q <= last_w && !start;
    end
  end

endmodule

`default_nettype wire

// [rtl/plcc_top.sv]
// The AXI4-Lite interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module plcc_top
  import plcc_pkg::*;
#(
  parameter int unsigned SETTLE0_CYCLES = plcc_pkg::SETTLE0_CYC,
  parameter int unsigned SETTLE1_CYCLES = plcc_pkg::SETTLE1_CYC,
  parameter int unsigned SETTLE2_CYCLES = plcc_pkg::SETTLE2_CYC,
  parameter int unsigned SETTLE3_CYCLES = plcc_pkg::SETTLE3_CYC,
  parameter int unsigned OSC0_CYCLES    = plcc_pkg::OSC0_CYC,
  parameter int unsigned OSC1_CYCLES    = plcc_pkg::OSC1_CYC,
  parameter int unsigned OSC2_CYCLES    = plcc_pkg::OSC2_CYC,
  parameter int unsigned OSC3_CYCLES    = plcc_pkg::OSC3_CYC
) (
  input  wire logic                              ref_clk,
  input  wire logic                              reset_n,
  input  wire logic [plcc_pkg::AXI_ADDR_W-1:0]   s_axi_awaddr,
  input  wire logic                              s_axi_awvalid,
  output logic                                   s_axi_awready,
  input  wire logic [plcc_pkg::AXI_DATA_W-1:0]   s_axi_wdata,
  input  wire logic [3:0]                        s_axi_wstrb,
  input  wire logic                              s_axi_wvalid,
  output logic                                   s_axi_wready,
  output logic [1:0]                             s_axi_bresp,
  output logic                                   s_axi_bvalid,
  input  wire logic                              s_axi_bready,
  input  wire logic [plcc_pkg::AXI_ADDR_W-1:0]   s_axi_araddr,
  input  wire logic                              s_axi_arvalid,
  output logic                                   s_axi_arready,
  output logic [plcc_pkg::AXI_DATA_W-1:0]        s_axi_rdata,
  output logic [1:0]                             s_axi_rresp,
  output logic                                   s_axi_rvalid,
  input  wire logic                              s_axi_rready,
  input  wire logic                              nv_load_valid,
  input  wire logic [7:0]                        nv_load_index,
  input  wire logic [7:0]                        nv_load_byte,
  input  wire logic                              cal_start_req,
  output logic [1:0]                             loop1_settle_wait_sel,
  output logic [1:0]                             loop1_osc_wait_sel,
  output logic                                   loop1_narrow_bandwidth,
  output logic                                   loop2_pulse_widen,
  output logic [2:0]                             loop2_filter_order_sel,
  output logic                                   loop2_third_order,
  output logic                                   cal_busy,
  output logic                                   cal_done
);
  import plcc_pkg::*;

  // ----------------------------------------------------------------
  // Elaboration checks on the wait lengths
  // ----------------------------------------------------------------
  localparam longint unsigned CNT_MAX = (64'd1 << WAIT_CNT_W) - 64'd1;

  if (SETTLE0_CYCLES < 1 || SETTLE1_CYCLES < 1 || SETTLE2_CYCLES < 1 ||
      SETTLE3_CYCLES < 1 || OSC0_CYCLES < 1 || OSC1_CYCLES < 1 ||
      OSC2_CYCLES < 1 || OSC3_CYCLES < 1) begin : g_len_zero
    $error("wait lengths must be at least one cycle");
  end
  if (SETTLE0_CYCLES > CNT_MAX || SETTLE1_CYCLES > CNT_MAX ||
      SETTLE2_CYCLES > CNT_MAX || SETTLE3_CYCLES > CNT_MAX ||
      OSC0_CYCLES > CNT_MAX || OSC1_CYCLES > CNT_MAX ||
      OSC2_CYCLES > CNT_MAX || OSC3_CYCLES > CNT_MAX) begin : g_len_wide
    $error("wait length does not fit the counter");
  end

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  logic [1:0]  settle_sel_q;
  logic [1:0]  osc_sel_q;
  logic        narrow_bw_q;
  logic        pulse_widen_q;
  logic [2:0]  filter_sel_q;
  logic        cal_done_q;
  plcc_cal_state_t cal_state_q;
  plcc_cal_state_t cal_state_d;

  // ----------------------------------------------------------------
  // AXI4-Lite write channel holding registers
  // ----------------------------------------------------------------
  logic                  aw_have_q;
  logic [7:0]            aw_index_q;
  logic                  w_have_q;
  logic [7:0]            w_byte_q;
  logic                  w_lane0_q;
  logic                  w_start_q;
  logic                  bvalid_q;
  logic [1:0]            bresp_q;
  logic                  aw_take;
  logic                  w_take;
  logic                  wr_fire;
  logic [7:0]            wr_index;
  logic [7:0]            wr_byte;
  logic                  wr_lane0;
  logic                  wr_start_bit;
  logic                  wr_hit;

  // Address and data are taken independently, one write in flight
  assign s_axi_awready = !aw_have_q && !bvalid_q;
  assign s_axi_wready  = !w_have_q && !bvalid_q;
  assign aw_take       = s_axi_awvalid && s_axi_awready;
  assign w_take        = s_axi_wvalid && s_axi_wready;
  assign wr_index      = aw_have_q ? aw_index_q : s_axi_awaddr[9:2];
  assign wr_byte       = w_have_q ? w_byte_q : s_axi_wdata[7:0];
  assign wr_lane0      = w_have_q ? w_lane0_q : s_axi_wstrb[0];
  assign wr_start_bit  = w_have_q ? w_start_q : s_axi_wdata[CAL_START_BIT];
  assign wr_fire       = (aw_have_q || aw_take) && (w_have_q || w_take);
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;

  // Unmapped or out-of-window addresses answer SLVERR
  logic aw_in_window;
  logic aw_in_window_q;
  assign aw_in_window = (s_axi_awaddr[AXI_ADDR_W-1:10] == '0);
  assign wr_hit = (aw_have_q ? aw_in_window_q : aw_in_window) &&
                  (wr_index == IDX_LOOP1_CAL_WAITS || wr_index == IDX_LOOP1_BW_SELECT ||
                   wr_index == IDX_CAL_CONTROL || wr_index == IDX_LOOP2_PULSE ||
                   wr_index == IDX_LOOP2_FILTER);

  // Write channel sequencing
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      aw_have_q      <= 1'b0;
      aw_index_q     <= 8'h00;
      aw_in_window_q <= 1'b0;
      w_have_q       <= 1'b0;
      w_byte_q       <= 8'h00;
      w_lane0_q      <= 1'b0;
      w_start_q      <= 1'b0;
      bvalid_q       <= 1'b0;
      bresp_q        <= RESP_OKAY;
    end else begin
      if (wr_fire) begin
        aw_have_q <= 1'b0;
        w_have_q  <= 1'b0;
        bvalid_q  <= 1'b1;
        bresp_q   <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else begin
        if (aw_take) begin
          aw_have_q      <= 1'b1;
          aw_index_q     <= s_axi_awaddr[9:2];
          aw_in_window_q <= aw_in_window;
        end
        if (w_take) begin
          w_have_q  <= 1'b1;
          w_byte_q  <= s_axi_wdata[7:0];
          w_lane0_q <= s_axi_wstrb[0];
          w_start_q <= s_axi_wdata[CAL_START_BIT];
        end
        if (bvalid_q && s_axi_bready) begin
          bvalid_q <= 1'b0;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Field update: bus write wins over a nonvolatile load
  // ----------------------------------------------------------------
  logic       sw_wr;
  logic       up_en;
  logic [7:0] up_index;
  logic [7:0] up_byte;
  logic       hit_waits;
  logic       hit_bw;
  logic       hit_pulse;
  logic       hit_filter;
  logic       sw_cal_start;

  assign sw_wr        = wr_fire && wr_hit && wr_lane0;
  assign up_en        = sw_wr || nv_load_valid;
  assign up_index     = sw_wr ? wr_index : nv_load_index;
  assign up_byte      = sw_wr ? wr_byte : nv_load_byte;
  assign hit_waits    = up_en && (up_index == IDX_LOOP1_CAL_WAITS);
  assign hit_bw       = up_en && (up_index == IDX_LOOP1_BW_SELECT);
  assign hit_pulse    = up_en && (up_index == IDX_LOOP2_PULSE);
  assign hit_filter   = up_en && (up_index == IDX_LOOP2_FILTER);
  assign sw_cal_start = sw_wr && (wr_index == IDX_CAL_CONTROL) && wr_start_bit;

  // Only documented field bits are stored; reserved bits have no flops
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      settle_sel_q  <= SETTLE_SEL_RST;
      osc_sel_q     <= OSC_SEL_RST;
      narrow_bw_q   <= NARROW_BW_RST;
      pulse_widen_q <= PULSE_WIDEN_RST;
      filter_sel_q  <= FILTER_SEL_RST;
    end else begin
      if (hit_waits) begin
        settle_sel_q <= up_byte[SETTLE_SEL_LSB +: 2];
        osc_sel_q    <= up_byte[OSC_SEL_LSB +: 2];
      end
      if (hit_bw) begin
        narrow_bw_q <= up_byte[NARROW_BW_BIT];
      end
      if (hit_pulse) begin
        pulse_widen_q <= up_byte[PULSE_WIDEN_BIT];
      end
      if (hit_filter) begin
        filter_sel_q <= up_byte[FILTER_SEL_LSB +: 3];
      end
    end
  end

  // ----------------------------------------------------------------
  // Analog control outputs
  // ----------------------------------------------------------------
  assign loop1_settle_wait_sel  = settle_sel_q;
  assign loop1_osc_wait_sel     = osc_sel_q;
  assign loop1_narrow_bandwidth = narrow_bw_q;
  assign loop2_pulse_widen      = pulse_widen_q;
  assign loop2_filter_order_sel = filter_sel_q;
  assign loop2_third_order      = (filter_sel_q == FILTER_THIRD_ORD);

  // ----------------------------------------------------------------
  // Wait length selection
  // ----------------------------------------------------------------
  logic [WAIT_CNT_W-1:0] settle_len;
  logic [WAIT_CNT_W-1:0] osc_len;
  logic [WAIT_CNT_W-1:0] timer_len;

  // Settle wait in always-running clock cycles
  assign settle_len = (settle_sel_q == 2'h0) ? WAIT_CNT_W'(SETTLE0_CYCLES) :
                      (settle_sel_q == 2'h1) ? WAIT_CNT_W'(SETTLE1_CYCLES) :
                      (settle_sel_q == 2'h2) ? WAIT_CNT_W'(SETTLE2_CYCLES) :
                                               WAIT_CNT_W'(SETTLE3_CYCLES);
  assign osc_len    = (osc_sel_q == 2'h0) ? WAIT_CNT_W'(OSC0_CYCLES) :
                      (osc_sel_q == 2'h1) ? WAIT_CNT_W'(OSC1_CYCLES) :
                      (osc_sel_q == 2'h2) ? WAIT_CNT_W'(OSC2_CYCLES) :
                                            WAIT_CNT_W'(OSC3_CYCLES);

  // ----------------------------------------------------------------
  // Calibration sequence: oscillator settle, then closed-loop settle
  // ----------------------------------------------------------------
  logic cal_go;
  logic timer_start;
  logic timer_busy;
  logic timer_done;

  // A start while busy is ignored so a running wait is not cut short
  assign cal_go      = (sw_cal_start || cal_start_req) && (cal_state_q == CAL_IDLE);
  assign timer_start = cal_go || ((cal_state_q == CAL_OSC_WAIT) && timer_done);
  assign timer_len   = cal_go ? osc_len : settle_len;

  plcc_wait_timer #(
    .CNT_W (WAIT_CNT_W)
  ) u_timer (
    .ref_clk (ref_clk),
    .reset_n (reset_n),
    .start   (timer_start),
    .length  (timer_len),
    .busy    (timer_busy),
    .done    (timer_done)
  );

  // Next-state logic
  always_comb begin
    cal_state_d = cal_state_q;
    case (cal_state_q)
      CAL_IDLE: begin
        if (cal_go) begin
          cal_state_d = CAL_OSC_WAIT;
        end
      end
      CAL_OSC_WAIT: begin
        if (timer_done) begin
          cal_state_d = CAL_LOOP_WAIT;
        end
      end
      CAL_LOOP_WAIT: begin
        if (timer_done) begin
          cal_state_d = CAL_IDLE;
        end
      end
      default: begin
        cal_state_d = CAL_IDLE;
      end
    endcase
  end

  // Done is sticky until the next start
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      cal_state_q <= CAL_IDLE;
      cal_done_q  <= 1'b0;
    end else begin
      cal_state_q <= cal_state_d;
      if ((cal_state_q == CAL_LOOP_WAIT) && timer_done) begin
        cal_done_q <= 1'b1;
      end else if (cal_go) begin
        cal_done_q <= 1'b0;
      end
    end
  end

  assign cal_busy = (cal_state_q != CAL_IDLE);
  assign cal_done = cal_done_q;

  // ----------------------------------------------------------------
  // AXI4-Lite read channel
  // ----------------------------------------------------------------
  logic                  ar_take;
  logic                  rvalid_q;
  logic [1:0]            rresp_q;
  logic [AXI_DATA_W-1:0] rdata_q;
  logic [7:0]            rd_index;
  logic                  rd_window;
  logic [7:0]            rd_byte;
  logic                  rd_hit;
  logic [7:0]            stat_byte;

  assign s_axi_arready = !rvalid_q;
  assign ar_take       = s_axi_arvalid && s_axi_arready;
  assign rd_index      = s_axi_araddr[9:2];
  assign rd_window     = (s_axi_araddr[AXI_ADDR_W-1:10] == '0);
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rresp   = rresp_q;
  assign s_axi_rdata   = rdata_q;

  // Status view of the sequence
  assign stat_byte = {4'h0, (cal_state_q == CAL_LOOP_WAIT) && timer_busy,
                      (cal_state_q == CAL_OSC_WAIT) && timer_busy,
                      cal_done_q, cal_busy};

  // Reserved positions are padded with zeros
  assign rd_byte =
    (rd_index == IDX_LOOP1_CAL_WAITS) ? {4'h0, settle_sel_q, osc_sel_q} :
    (rd_index == IDX_LOOP1_BW_SELECT) ? {7'h00, narrow_bw_q} :
    (rd_index == IDX_CAL_CONTROL)     ? stat_byte :
    (rd_index == IDX_LOOP2_PULSE)     ? {pulse_widen_q, 7'h00} :
    (rd_index == IDX_LOOP2_FILTER)    ? {5'h00, filter_sel_q} :
                                        8'h00;
  assign rd_hit = rd_window &&
                  (rd_index == IDX_LOOP1_CAL_WAITS || rd_index == IDX_LOOP1_BW_SELECT ||
                   rd_index == IDX_CAL_CONTROL || rd_index == IDX_LOOP2_PULSE ||
                   rd_index == IDX_LOOP2_FILTER);

  // One read in flight; data held until rready
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      rvalid_q <= 1'b0;
      rresp_q  <= RESP_OKAY;
      rdata_q  <= 32'h0000_0000;
    end else if (ar_take) begin
      rvalid_q <= 1'b1;
      rresp_q  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      rdata_q  <= rd_hit ? {24'h00_0000, rd_byte} : 32'h0000_0000;
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

endmodule

`default_nettype wire

// [bench/plcc_monitor.sv]
`timescale 1ns/1ps
`default_nettype none

module plcc_monitor #(
  parameter int unsigned OSC3_CYCLES    = 1,
  parameter int unsigned SETTLE3_CYCLES = 1
) (
  input wire logic       ref_clk,
  input wire logic       reset_n,
  input wire logic       s_axi_bvalid,
  input wire logic       s_axi_bready,
  input wire logic       s_axi_arready,
  input wire logic       s_axi_rvalid,
  input wire logic       nv_load_valid,
  input wire logic       cal_start_req,
  input wire logic       cal_busy,
  input wire logic       cal_done,
  input wire logic [1:0] loop1_settle_wait_sel,
  input wire logic [1:0] loop1_osc_wait_sel,
  input wire logic       loop1_narrow_bandwidth,
  input wire logic       loop2_pulse_widen,
  input wire logic [2:0] loop2_filter_order_sel,
  input wire logic       loop2_third_order
);
  // Fields packed so one compare covers all of them
  wire [9:0] flds = {loop1_settle_wait_sel, loop1_osc_wait_sel, loop1_narrow_bandwidth,
                     loop2_pulse_widen, loop2_filter_order_sel, loop2_third_order};
  localparam int CAL_MAX = OSC3_CYCLES + SETTLE3_CYCLES + 4;
  int busy_cnt_q;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  // Busy length; a runaway wait shows up as an overlong count
  always_ff @(posedge ref_clk) begin
    if (!reset_n || !cal_busy) busy_cnt_q <= 0;
    else busy_cnt_q <= busy_cnt_q + 1;
  end
  reset_vals_a: assert property ($rose(reset_n) |-> flds == 10'h046)
    else $error("reset field value");
  third_dec_a: assert property (loop2_third_order == (loop2_filter_order_sel == 3'h7))
    else $error("third order decode");
  field_hold_a: assert property (!$stable(flds) |-> $rose(s_axi_bvalid) || $past(nv_load_valid))
    else $error("field changed without write");
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped");
  ar_ready_a: assert property (s_axi_arready == !s_axi_rvalid)
    else $error("read address ready");
  cal_start_a: assert property (cal_start_req && !cal_busy |=> cal_busy && !cal_done)
    else $error("calibration start");
  busy_done_a: assert property (!(cal_busy && cal_done))
    else $error("busy and done together");
  cal_bound_a: assert property (busy_cnt_q <= CAL_MAX)
    else $error("calibration too long");
  cover property (s_axi_bvalid && s_axi_bready);
  cover property ($fell(cal_busy));
  cover property (loop2_third_order);
endmodule

bind plcc_top plcc_monitor #(.OSC3_CYCLES(OSC3_CYCLES), .SETTLE3_CYCLES(SETTLE3_CYCLES))
  plcc_monitor_i (.ref_clk, .reset_n, .s_axi_bvalid, .s_axi_bready, .s_axi_arready,
  .s_axi_rvalid, .nv_load_valid, .cal_start_req, .cal_busy, .cal_done, .loop1_settle_wait_sel,
  .loop1_osc_wait_sel, .loop1_narrow_bandwidth, .loop2_pulse_widen, .loop2_filter_order_sel,
  .loop2_third_order);
`default_nettype wire

// [bench/pll_loop_calibration_config_bench.sv]
`timescale 1ns/1ps
`default_nettype none

module pll_loop_calibration_config_bench;
  import plcc_pkg::*;
  logic ref_clk = 0, reset_n = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0, nv_load_valid = 0, cal_start_req = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, cal_busy;
  logic loop1_narrow_bandwidth, loop2_pulse_widen, loop2_third_order, cal_done;
  logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 0;
  logic [1:0] s_axi_bresp, s_axi_rresp, loop1_settle_wait_sel, loop1_osc_wait_sel;
  logic [7:0] nv_load_index = 0, nv_load_byte = 0;
  logic [2:0] loop2_filter_order_sel;
  logic [33:0] exp_q[$], e;
  int error_cnt = 0, checks_done = 0, cyc = 0, seed = 32'hfe23, n, i, k;
  logic [7:0] d;
  localparam int OSC[4] = '{3, 4, 6, 8};
  localparam int SET[4] = '{5, 7, 9, 11};
  localparam logic [7:0] IDX[4] = '{IDX_LOOP1_CAL_WAITS, IDX_LOOP1_BW_SELECT, IDX_LOOP2_PULSE,
                                    IDX_LOOP2_FILTER};
  localparam logic [7:0] MSK[4] = '{8'h0F, 8'h01, 8'h80, 8'h07};
  localparam logic [7:0] RST[4] = '{8'h01, 8'h00, 8'h00, 8'h03};

  plcc_top #(.SETTLE0_CYCLES(SET[0]), .SETTLE1_CYCLES(SET[1]), .SETTLE2_CYCLES(SET[2]),
    .SETTLE3_CYCLES(SET[3]), .OSC0_CYCLES(OSC[0]), .OSC1_CYCLES(OSC[1]),
    .OSC2_CYCLES(OSC[2]), .OSC3_CYCLES(OSC[3])) plcc_top_i (.ref_clk, .reset_n,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .nv_load_valid,
    .nv_load_index, .nv_load_byte, .cal_start_req, .loop1_settle_wait_sel, .loop1_osc_wait_sel,
    .loop1_narrow_bandwidth, .loop2_pulse_widen, .loop2_filter_order_sel, .loop2_third_order,
    .cal_busy, .cal_done);

  always #2 ref_clk = ~ref_clk;

  task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic test_done;
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // One bus transfer; handshakes sampled at the falling edge, released at the next rise
  task automatic bus(input logic we, input logic [7:0] x, input logic [7:0] v,
                     input logic [3:0] s, input logic [33:0] ex);
    logic aw, w, fin;
    exp_q.push_back(ex);
    @(posedge ref_clk);
    s_axi_awaddr <= {2'b00, x, 2'b00};
    s_axi_araddr <= {2'b00, x, 2'b00};
    s_axi_wdata <= {24'h00_0000, v};
    s_axi_wstrb <= s;
    s_axi_awvalid <= we;
    s_axi_wvalid <= we;
    s_axi_bready <= we;
    s_axi_arvalid <= !we;
    s_axi_rready <= !we;
    fin = 1'b0;
    while (!fin) begin
      @(negedge ref_clk);
      aw = s_axi_awvalid && s_axi_awready;
      w = s_axi_wvalid && s_axi_wready;
      fin = we ? s_axi_bvalid : s_axi_rvalid;
      @(posedge ref_clk);
      if (aw) s_axi_awvalid <= 1'b0;
      if (w) s_axi_wvalid <= 1'b0;
      if (!we) s_axi_arvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
    s_axi_rready <= 1'b0;
  endtask

  // Response checker takes the oldest expectation per answer
  always @(negedge ref_clk) begin
    if (s_axi_bvalid && s_axi_bready) begin
      e = exp_q.pop_front();
      cmp("bresp", 32'(e[33:32]), 32'(s_axi_bresp));
    end
    if (s_axi_rvalid && s_axi_rready) begin
      e = exp_q.pop_front();
      cmp("rresp", 32'(e[33:32]), 32'(s_axi_rresp));
      cmp("rdata", e[31:0], s_axi_rdata);
    end
  end

  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      test_done;
    end
  end

  initial begin
    repeat (2) @(posedge ref_clk);
    reset_n <= 1'b1;
    for (i = 0; i < 4; i++) bus(0, IDX[i], 0, 0, {26'h0, RST[i]});
    for (i = 0; i < 4; i++) begin
      bus(1, IDX[i], 8'hFF, 4'hF, 0);
      bus(0, IDX[i], 0, 0, {26'h0, MSK[i]});
    end
    @(negedge ref_clk);
    cmp("fields", 32'h3FF, {22'h0, loop1_settle_wait_sel, loop1_osc_wait_sel,
        loop1_narrow_bandwidth, loop2_pulse_widen, loop2_filter_order_sel,
        loop2_third_order});
    bus(1, IDX_LOOP2_FILTER, 8'h03, 4'h0, 0);
    bus(0, IDX_LOOP2_FILTER, 0, 0, 34'h07);
    bus(1, 8'h01, 8'hFF, 4'hF, {RESP_SLVERR, 32'h0});
    bus(0, 8'h01, 0, 0, {RESP_SLVERR, 32'h0});
    @(posedge ref_clk);
    nv_load_valid <= 1'b1;
    nv_load_index <= IDX_LOOP2_FILTER;
    nv_load_byte <= 8'h03;
    @(posedge ref_clk);
    nv_load_valid <= 1'b0;
    @(negedge ref_clk);
    cmp("third", 0, 32'(loop2_third_order));
    repeat (10) begin
      i = {$random(seed)} % 4;
      d = 8'($random(seed)) & MSK[i];
      if (i == 3) d[2:0] = d[0] ? 3'h7 : 3'h3;
      bus(1, IDX[i], d, 4'hF, 0);
      bus(0, IDX[i], 0, 0, {26'h0, d & MSK[i]});
    end
    for (k = 0; k < 4; k++) begin
      bus(1, IDX_LOOP1_CAL_WAITS, 8'(k * 5), 4'hF, 0);
      if (k < 3) begin
        @(posedge ref_clk);
        cal_start_req <= 1'b1;
        @(posedge ref_clk);
        cal_start_req <= 1'b0;
      end else bus(1, IDX_CAL_CONTROL, 8'h01, 4'hF, 0);
      n = 0;
      @(negedge ref_clk);
      while (cal_busy) begin
        n++;
        @(negedge ref_clk);
      end
      cmp("cal_len", 1, 32'(n >= OSC[k] + SET[k] - 2 && n <= OSC[k] + SET[k] + 2));
      bus(0, IDX_CAL_CONTROL, 0, 0, 34'h02);
    end
    // Status mid oscillator wait: busy and osc-wait bits up, done cleared
    bus(1, IDX_CAL_CONTROL, 8'h01, 4'hF, 0);
    bus(0, IDX_CAL_CONTROL, 0, 0, 34'h05);
    while (cal_busy) @(negedge ref_clk);
    test_done;
  end
endmodule
`default_nettype wire
